// [fblc_defs.vh]
/*
 * Constants of the flash block lock controller: command codes, status bit
 * positions, lock status offset and controller register map.
 * Assumes inclusion by the fblc_wb_slave and fblc_ctrl design files of the controller.
 */
`ifndef FBLC_DEFS_VH
`define FBLC_DEFS_VH

// --------------------------------------------------------------------------
// Flash command codes
// --------------------------------------------------------------------------
`define FBLC_CMD_CFG_SETUP 8'h60
`define FBLC_CMD_LOCK 8'h01
`define FBLC_CMD_UNLOCK 8'hd0
`define FBLC_CMD_LOCKDOWN 8'h2f
`define FBLC_CMD_READ_CFG 8'h90
`define FBLC_CMD_READ_STATUS 8'h70
`define FBLC_CMD_CLEAR_STATUS 8'h50
`define FBLC_CMD_READ_ARRAY 8'hff
`define FBLC_CMD_ERASE_SUSPEND 8'hb0
`define FBLC_CMD_ERASE_RESUME 8'hd0

// --------------------------------------------------------------------------
// Flash status and lock status bits
// --------------------------------------------------------------------------
`define FBLC_SR_READY 7
`define FBLC_SR_ERASE_SUSP 6
`define FBLC_SR_ERASE_FAIL 5
`define FBLC_SR_PROG_FAIL 4
`define FBLC_SR_PROG_SUSP 2
`define FBLC_SR_LOCK_VIOL 1
`define FBLC_LS_LOCK 0
`define FBLC_LS_LOCKDOWN 1
`define FBLC_LS_OFFSET 22'h000002

// --------------------------------------------------------------------------
// Controller register map (byte offsets)
// --------------------------------------------------------------------------
`define FBLC_REG_CTRL 4'h0
`define FBLC_REG_ADDR 4'h4
`define FBLC_REG_STATUS 4'h8
`define FBLC_REG_DATA 4'hc

// Control register fields.
`define FBLC_CTRL_OP_LSB 0
`define FBLC_CTRL_OP_MSB 2
`define FBLC_CTRL_START 3
`define FBLC_CTRL_WP 4
`define FBLC_CTRL_WP_RST 8'h00

// Operation codes.
`define FBLC_OP_LOCK 3'h0
`define FBLC_OP_UNLOCK 3'h1
`define FBLC_OP_LOCKDOWN 3'h2
`define FBLC_OP_READ_LOCK 3'h3
`define FBLC_OP_READ_STATUS 3'h4
`define FBLC_OP_SUSPEND 3'h5
`define FBLC_OP_RESUME 3'h6
`define FBLC_OP_CLEAR_STATUS 3'h7

// Status register fields.
`define FBLC_ST_BUSY 0
`define FBLC_ST_LOCK 1
`define FBLC_ST_LOCKDOWN 2
`define FBLC_ST_LOCK_VIOL 3
`define FBLC_ST_CMD_ERR 4
`define FBLC_ST_PROG_SUSP 5
`define FBLC_ST_REFUSED 6

// --------------------------------------------------------------------------
// Bus timing
// --------------------------------------------------------------------------
`define FBLC_T_WE_NS 60
`define FBLC_T_RD_NS 80
`define FBLC_CLK_NS 20
`define FBLC_T_WE_CYC ((`FBLC_T_WE_NS + `FBLC_CLK_NS - 1) / `FBLC_CLK_NS)
`define FBLC_T_RD_CYC ((`FBLC_T_RD_NS + `FBLC_CLK_NS - 1) / `FBLC_CLK_NS)
`define FBLC_WP_HOLD_CYC 3

`endif

// [fblc_sync.v]
/*
 * Two flip-flop synchroniser for a vector of pin inputs.
 * Assumes one clock; inputs come from outside that clock's domain.
 */
`timescale 1ns/1ps
module fblc_sync #(
	parameter WIDTH = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Data
	input wire [WIDTH-1:0] async_i,
	output reg [WIDTH-1:0] sync_o
);
	reg [WIDTH-1:0] meta_reg;

	always @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= {WIDTH{1'b0}};
			sync_o <= {WIDTH{1'b0}};
		end else begin
			meta_reg <= async_i;
			sync_o <= meta_reg;
		end
	end
endmodule // fblc_sync

// [fblc_wb_slave.v]
/*
 * Classic Wishbone slave holding the controller's control and address
 * registers, and showing status and read data.
 * Assumes a single-cycle classic master; ack follows one cycle after stb.
 */
`timescale 1ns/1ps
`include "fblc_defs.vh"
module fblc_wb_slave #(
	parameter AW = 22
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// Controller side
	output reg [2:0] op_o,
	output reg start_o,
	output reg wp_o,
	output reg [AW-1:0] addr_o,
	input wire [7:0] status_i,
	input wire [15:0] rdata_i
);
	wire hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			op_o <= 3'h0;
			start_o <= 1'b0;
			wp_o <= 1'b0;
			addr_o <= {AW{1'b0}};
		end else begin
			wb_ack_o <= hit;
			start_o <= 1'b0;
			if (hit) begin
				wb_dat_o <= 32'h0;
				case (wb_adr_i)
				`FBLC_REG_CTRL: begin
					wb_dat_o <= {27'h0, wp_o, 1'b0, op_o};
					if (wb_we_i && wb_sel_i[0]) begin
						op_o <= wb_dat_i[`FBLC_CTRL_OP_MSB:`FBLC_CTRL_OP_LSB];
						start_o <= wb_dat_i[`FBLC_CTRL_START];
						wp_o <= wb_dat_i[`FBLC_CTRL_WP];
					end
				end
				`FBLC_REG_ADDR: begin
					wb_dat_o <= {{(32-AW){1'b0}}, addr_o};
					if (wb_we_i)
						addr_o <= wb_dat_i[AW-1:0];
				end
				`FBLC_REG_STATUS: wb_dat_o <= {24'h0, status_i};
				`FBLC_REG_DATA: wb_dat_o <= {16'h0, rdata_i};
				default: wb_dat_o <= 32'h0;
				endcase
			end
		end
	end
endmodule // fblc_wb_slave

// [fblc_ctrl.v]
/*
 * Flash block lock controller: drives the lock, unlock and lock-down
 * command sequences, reads lock status and status register, handles erase
 * suspend and resume, and drives the write-protect pin.
 * Assumes an asynchronous flash bus with active-low strobes; the flash
 * data inputs are synchronised before use.
 */
//
// Summary of operation
// (R1) Flash blocks start locked after reset.
// (R2) Program on locked block sets violation flag.
// (R3) Lock is 60h then 01h.
// (R4) Unlock is 60h then D0h.
// (R5) Lock-down is 60h then 2Fh.
// (R6) Locked-down block refuses changes while protect low.
// (R7) Protect high lets locked-down blocks unlock.
// (R8) Protect falling restores lock-down state.
// (R9) Reset clears lock-down and sets lock.
// (R10) After 90h, base plus 2 reads lock bits.
// (R11) Only reset clears the lock-down bit.
// (R12) Lock commands take effect at once.
// (R13) Suspend erase with B0h, poll, then resume D0h.
// (R14) Locking a suspended erase block still completes.
// (R15) No lock commands during program suspend.
// (R16) Bad second code sets both fail flags.
// (R17) Command error flags survive erase resume.
// (R18) Protection register has two 64-bit halves.
// (R19) Keep write-protect low by default.
// (R20) Hold protect three cycles during unlock.
// (R21) Second cycle addresses the target block.
`timescale 1ns/1ps
`include "fblc_defs.vh"
module fblc_ctrl #(
	parameter AW = 22,
	parameter DW = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [3:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire wb_ack_o,
	// Flash bus
	output reg [AW-1:0] fl_addr_o,
	output reg [DW-1:0] fl_dq_o,
	output reg fl_dq_oe_o,
	input wire [DW-1:0] fl_dq_i,
	output reg fl_ce_n_o,
	output reg fl_oe_n_o,
	output reg fl_we_n_o,
	output reg fl_wp_n_o,
	output reg fl_rst_n_o
);
	// ----------------------------------------------------------------------
	// States
	// ----------------------------------------------------------------------
	localparam [5:0] S_IDLE = 6'h01;
	localparam [5:0] S_WR1 = 6'h02;
	localparam [5:0] S_GAP = 6'h04;
	localparam [5:0] S_WR2 = 6'h08;
	localparam [5:0] S_RD = 6'h10;
	localparam [5:0] S_HOLD = 6'h20;

	// ----------------------------------------------------------------------
	// Timing counts
	// ----------------------------------------------------------------------
	localparam integer WE_CYC_N = `FBLC_T_WE_CYC;
	localparam integer RD_CYC_N = `FBLC_T_RD_CYC;
	localparam integer WP_CYC_N = `FBLC_WP_HOLD_CYC;
	localparam [3:0] WE_CYC = WE_CYC_N[3:0];
	localparam [3:0] RD_CYC = RD_CYC_N[3:0];
	localparam [3:0] WP_CYC = WP_CYC_N[3:0];

	// ----------------------------------------------------------------------
	// Register slave and pin synchroniser
	// ----------------------------------------------------------------------
	wire [2:0] op;
	wire start;
	wire wp_req;
	wire [AW-1:0] addr;
	wire [DW-1:0] dq_sync;
	reg [7:0] status_reg;
	reg [DW-1:0] rdata_reg;

	fblc_wb_slave #(.AW(AW)) u_slave (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.op_o(op),
		.start_o(start),
		.wp_o(wp_req),
		.addr_o(addr),
		.status_i(status_reg),
		.rdata_i(rdata_reg)
	);

	fblc_sync #(.WIDTH(DW)) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.async_i(fl_dq_i),
		.sync_o(dq_sync)
	);

	// ----------------------------------------------------------------------
	// Sequencing
	// ----------------------------------------------------------------------
	function is_lock_op;
		input [2:0] o;
		begin
			is_lock_op = (o == `FBLC_OP_LOCK) || (o == `FBLC_OP_UNLOCK) || (o == `FBLC_OP_LOCKDOWN);
		end
	endfunction

	function [7:0] second_code;
		input [2:0] o;
		begin
			case (o)
			`FBLC_OP_LOCK: second_code = `FBLC_CMD_LOCK;
			`FBLC_OP_UNLOCK: second_code = `FBLC_CMD_UNLOCK;
			`FBLC_OP_LOCKDOWN: second_code = `FBLC_CMD_LOCKDOWN;
			default: second_code = 8'h00;
			endcase
		end
	endfunction

	function [7:0] first_code;
		input [2:0] o;
		begin
			case (o)
			`FBLC_OP_READ_LOCK: first_code = `FBLC_CMD_READ_CFG;
			`FBLC_OP_READ_STATUS: first_code = `FBLC_CMD_READ_STATUS;
			`FBLC_OP_SUSPEND: first_code = `FBLC_CMD_ERASE_SUSPEND;
			`FBLC_OP_RESUME: first_code = `FBLC_CMD_ERASE_RESUME;
			`FBLC_OP_CLEAR_STATUS: first_code = `FBLC_CMD_CLEAR_STATUS;
			default: first_code = `FBLC_CMD_CFG_SETUP;
			endcase
		end
	endfunction

	// ----------------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------------
	reg [5:0] state_reg;
	reg [2:0] op_reg;
	reg [3:0] cnt_reg;
	reg prog_susp_reg;
	reg wp_hold_reg;

	wire refuse = is_lock_op(op) && prog_susp_reg; // (R15)
	wire has_read = (op_reg == `FBLC_OP_READ_LOCK) || (op_reg == `FBLC_OP_READ_STATUS);
	wire busy = (state_reg != S_IDLE);
	wire rd_done = (state_reg == S_RD) && (cnt_reg <= 4'h1);

	// ----------------------------------------------------------------------
	// Pins driven outside the command sequence
	// ----------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i) begin
			fl_wp_n_o <= 1'b0; // (R19)
			fl_rst_n_o <= 1'b0; // (R9)
		end else begin
			fl_rst_n_o <= 1'b1;
			if (!wp_hold_reg)
				fl_wp_n_o <= wp_req; // (R7) (R8)
		end
	end

	// ----------------------------------------------------------------------
	// Read data capture
	// ----------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i)
			rdata_reg <= {DW{1'b0}};
		else if (rd_done)
			rdata_reg <= dq_sync; // (R10)
	end

	// ----------------------------------------------------------------------
	// Command state machine
	// ----------------------------------------------------------------------

	always @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= S_IDLE;
			op_reg <= 3'h0;
			cnt_reg <= 4'h0;
			fl_addr_o <= {AW{1'b0}};
			fl_dq_o <= {DW{1'b0}};
			fl_dq_oe_o <= 1'b0;
			fl_ce_n_o <= 1'b1;
			fl_oe_n_o <= 1'b1;
			fl_we_n_o <= 1'b1;
			wp_hold_reg <= 1'b0;
			status_reg <= 8'h00;
			prog_susp_reg <= 1'b0;
		end else begin
			case (state_reg)
			S_IDLE: begin
				if (start && refuse) begin
					status_reg[`FBLC_ST_REFUSED] <= 1'b1;
				end else if (start) begin
					status_reg[`FBLC_ST_REFUSED] <= 1'b0;
					op_reg <= op;
					fl_addr_o <= addr; // (R21)
					fl_dq_o <= {{(DW-8){1'b0}}, first_code(op)}; // (R3) (R4) (R5) (R13)
					fl_dq_oe_o <= 1'b1;
					fl_ce_n_o <= 1'b0;
					fl_we_n_o <= 1'b0;
					wp_hold_reg <= (op == `FBLC_OP_UNLOCK); // (R20)
					cnt_reg <= WE_CYC;
					state_reg <= S_WR1;
				end
			end
			S_WR1: begin
				if (cnt_reg > 4'h1) begin
					cnt_reg <= cnt_reg - 4'h1;
				end else begin
					fl_we_n_o <= 1'b1;
					fl_ce_n_o <= 1'b1;
					cnt_reg <= 4'h1;
					state_reg <= S_GAP;
				end
			end
			S_GAP: begin
				fl_ce_n_o <= 1'b0;
				if (is_lock_op(op_reg)) begin
					fl_dq_o <= {{(DW-8){1'b0}}, second_code(op_reg)}; // (R12)
					fl_we_n_o <= 1'b0;
					cnt_reg <= WE_CYC;
					state_reg <= S_WR2;
				end else if (has_read) begin
					fl_dq_oe_o <= 1'b0;
					fl_oe_n_o <= 1'b0;
					if (op_reg == `FBLC_OP_READ_LOCK)
						fl_addr_o <= addr + `FBLC_LS_OFFSET; // (R10)
					cnt_reg <= RD_CYC + 4'h2;
					state_reg <= S_RD;
				end else begin
					fl_ce_n_o <= 1'b1;
					fl_dq_oe_o <= 1'b0;
					if (op_reg == `FBLC_OP_CLEAR_STATUS)
						status_reg[`FBLC_ST_CMD_ERR:`FBLC_ST_LOCK_VIOL] <= 2'b00; // (R17)
					state_reg <= S_IDLE;
				end
			end
			S_WR2: begin
				if (cnt_reg > 4'h1) begin
					cnt_reg <= cnt_reg - 4'h1;
				end else begin
					fl_we_n_o <= 1'b1;
					fl_ce_n_o <= 1'b1;
					fl_dq_oe_o <= 1'b0;
					cnt_reg <= WP_CYC;
					state_reg <= S_HOLD;
				end
			end
			S_HOLD: begin
				if (cnt_reg > 4'h1) begin
					cnt_reg <= cnt_reg - 4'h1;
				end else begin
					wp_hold_reg <= 1'b0;
					state_reg <= S_IDLE;
				end
			end
			S_RD: begin
				if (cnt_reg > 4'h1) begin
					cnt_reg <= cnt_reg - 4'h1;
				end else begin
					fl_oe_n_o <= 1'b1;
					fl_ce_n_o <= 1'b1;
					if (op_reg == `FBLC_OP_READ_LOCK) begin
						status_reg[`FBLC_ST_LOCK] <= dq_sync[`FBLC_LS_LOCK]; // (R1) (R10)
						status_reg[`FBLC_ST_LOCKDOWN] <= dq_sync[`FBLC_LS_LOCKDOWN]; // (R6) (R11)
					end else begin
						prog_susp_reg <= dq_sync[`FBLC_SR_PROG_SUSP]; // (R15)
						status_reg[`FBLC_ST_PROG_SUSP] <= dq_sync[`FBLC_SR_PROG_SUSP];
						status_reg[`FBLC_ST_LOCK_VIOL] <= status_reg[`FBLC_ST_LOCK_VIOL] |
							dq_sync[`FBLC_SR_LOCK_VIOL]; // (R2)
						status_reg[`FBLC_ST_CMD_ERR] <= status_reg[`FBLC_ST_CMD_ERR] |
							(dq_sync[`FBLC_SR_PROG_FAIL] & dq_sync[`FBLC_SR_ERASE_FAIL]); // (R16) (R17)
					end
					state_reg <= S_IDLE;
				end
			end
			default: state_reg <= S_IDLE;
			endcase
			status_reg[`FBLC_ST_BUSY] <= busy;
		end
	end
endmodule // fblc_ctrl

// [fblc_chk.sv]
/*
 * Port assertions of the flash block lock controller.
 * Assumes binding into fblc_ctrl, one clock and synchronous reset.
 */
`timescale 1ns/1ps
module fblc_chk #(
	parameter DW = 16
) (
	// Clock and reset
	input wire clk_i,
	input wire rst_i,
	// Wishbone
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_ack_o,
	// Flash bus
	input wire [DW-1:0] fl_dq_o,
	input wire fl_dq_oe_o,
	input wire fl_ce_n_o,
	input wire fl_oe_n_o,
	input wire fl_we_n_o,
	input wire fl_wp_n_o,
	input wire fl_rst_n_o
);
	// ----------------
	// Checks
	// ----------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence setup_s;
		$fell(fl_we_n_o) && fl_dq_o == 16'h0060;
	endsequence
	sequence second_s;
		$fell(fl_we_n_o) && (fl_dq_o == 16'h0001 || fl_dq_o == 16'h00d0 || fl_dq_o == 16'h002f);
	endsequence
	sequence unlock_s;
		$fell(fl_we_n_o) && fl_dq_o == 16'h00d0 && $past(fl_dq_o, 4) == 16'h0060;
	endsequence
	reset_idle_a: assert property (disable iff (1'h0) rst_i |=> !fl_rst_n_o && !fl_wp_n_o && fl_we_n_o && fl_ce_n_o)
		else $error("flash bus not idle in reset");
	reset_release_a: assert property (disable iff (1'h0) $fell(rst_i) |-> !fl_rst_n_o ##1 fl_rst_n_o)
		else $error("flash reset release wrong");
	cmd_pair_a: assert property (setup_s |-> ##4 second_s)
		else $error("setup code not followed by lock code");
	we_width_a: assert property ($fell(fl_we_n_o) |-> !fl_we_n_o [*3] ##1 fl_we_n_o)
		else $error("write pulse width wrong");
	write_drive_a: assert property (!fl_we_n_o |-> fl_dq_oe_o && !fl_ce_n_o && fl_oe_n_o)
		else $error("write cycle not driven");
	read_free_a: assert property (!fl_oe_n_o |-> !fl_dq_oe_o && fl_we_n_o && !fl_ce_n_o)
		else $error("read cycle contends");
	wp_hold_a: assert property (unlock_s |-> $stable(fl_wp_n_o) [*7])
		else $error("protect pin moved in unlock");
	ack_pulse_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one pulse");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
endmodule // fblc_chk

bind fblc_ctrl fblc_chk #(.DW(DW)) fblc_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fl_dq_o(fl_dq_o), .fl_dq_oe_o(fl_dq_oe_o), .fl_ce_n_o(fl_ce_n_o),
	.fl_oe_n_o(fl_oe_n_o), .fl_we_n_o(fl_we_n_o), .fl_wp_n_o(fl_wp_n_o), .fl_rst_n_o(fl_rst_n_o));

// [fblc_flash_model.sv]
/*
 * Flash model with four blocks of lock and lock-down bits.
 * Assumes block index in address bits 21:20 and bench clock.
 */
`timescale 1ns/1ps
module fblc_flash_model (
	// Clock
	input wire clk_i,
	// Flash bus
	input wire [21:0] addr_i,
	input wire [15:0] dq_i,
	output wire [15:0] dq_o,
	input wire ce_n_i,
	input wire oe_n_i,
	input wire we_n_i,
	input wire wp_n_i,
	input wire rst_n_i,
	// State
	input wire prog_susp_i,
	input wire [1:0] inj_i
);
	// ----------------
	// Lock state
	// ----------------
	reg [3:0] lk_reg, ld_reg;
	reg setup_reg, cfg_reg, esus_reg, pf_reg, ef_reg, we_reg, wp_reg;
	wire [1:0] blk = addr_i[21:20];
	wire hold = ld_reg[blk] && !wp_n_i;
	localparam [63:0] PR_FIXED = 64'h3c5a_96e1_0f7b_24d8; // Arbitrary value.
	wire [127:0] pr = {64'hffff_ffff_ffff_ffff, PR_FIXED};
	wire [15:0] pr_word = pr[addr_i[2:0] * 16 +: 16];
	wire [7:0] sr = {1'h1, esus_reg, ef_reg, pf_reg, 1'h0, prog_susp_i, inj_i[0], 1'h0};
	wire [15:0] lk_word = (addr_i[19:0] == 20'h00002) ? {14'h0, ld_reg[blk], lk_reg[blk]} : pr_word;
	wire [15:0] rd = cfg_reg ? lk_word : {8'h00, sr};
	assign dq_o = (!ce_n_i && !oe_n_i) ? rd : ({16{clk_i}} ^ 16'h5a5a);
	always @(posedge clk_i) begin
		we_reg <= we_n_i;
		wp_reg <= wp_n_i;
		if (!rst_n_i) begin
			lk_reg <= 4'hf;
			ld_reg <= 4'h0;
			{setup_reg, cfg_reg, esus_reg, pf_reg, ef_reg} <= 5'h00;
		end else begin
			if (wp_reg && !wp_n_i)
				lk_reg <= lk_reg | ld_reg;
			if (we_reg && !we_n_i && !ce_n_i) begin
				setup_reg <= 1'h0;
				if (setup_reg && !prog_susp_i) begin
					case (inj_i[1] ? 8'h00 : dq_i[7:0])
					8'h01: if (!hold) lk_reg[blk] <= 1'h1;
					8'hd0: if (!hold) lk_reg[blk] <= 1'h0;
					8'h2f: if (!hold) {ld_reg[blk], lk_reg[blk]} <= 2'h3;
					default: {pf_reg, ef_reg} <= 2'h3;
					endcase
				end else begin
					case (dq_i[7:0])
					8'h60: setup_reg <= 1'h1;
					8'h90: cfg_reg <= 1'h1;
					8'h70: cfg_reg <= 1'h0;
					8'h50: {pf_reg, ef_reg} <= 2'h0;
					8'hb0: esus_reg <= 1'h1;
					8'hd0: esus_reg <= 1'h0;
					default: cfg_reg <= 1'h0;
					endcase
				end
			end
		end
	end
endmodule // fblc_flash_model

// [flash_block_lock_control_bench.sv]
/*
 * Bench of the flash block lock controller over Wishbone.
 * Assumes the flash model on the far side of the flash bus.
 */
`timescale 1ns/1ps
module flash_block_lock_control_bench;
	// ----------------
	// Signals
	// ----------------
	reg clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, psusp = 1'h0;
	reg [3:0] wb_adr_i = 4'h0;
	reg [3:0] wb_sel_i = 4'h0;
	reg [1:0] inj = 2'h0;
	reg [31:0] wb_dat_i = 32'h0, rd, st;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, dq_oe, ce_n, oe_n, we_n, wp_n, frst_n;
	wire [21:0] fa;
	wire [15:0] dq_o, mdq;
	wire [15:0] dq = dq_oe ? dq_o : mdq;
	integer error_cnt = 0, samples_checked = 0, cyc_cnt = 0, b;
	initial forever #10 clk_i = ~clk_i;
	fblc_ctrl fblc_ctrl_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .fl_addr_o(fa), .fl_dq_o(dq_o), .fl_dq_oe_o(dq_oe), .fl_dq_i(dq), .fl_ce_n_o(ce_n),
		.fl_oe_n_o(oe_n), .fl_we_n_o(we_n), .fl_wp_n_o(wp_n), .fl_rst_n_o(frst_n));
	fblc_flash_model fblc_flash_model_inst (.clk_i(clk_i), .addr_i(fa), .dq_i(dq), .dq_o(mdq), .ce_n_i(ce_n),
		.oe_n_i(oe_n), .we_n_i(we_n), .wp_n_i(wp_n), .rst_n_i(frst_n), .prog_susp_i(psusp), .inj_i(inj));
	// ----------------
	// Tasks
	// ----------------
	task stop_test;
		begin
			$display("errors %0d checks %0d", error_cnt, samples_checked);
			if (error_cnt == 0 && samples_checked > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	always @(posedge clk_i) begin
		cyc_cnt <= cyc_cnt + 1;
		if (cyc_cnt == 20000) begin
			error_cnt = error_cnt + 1;
			stop_test;
		end
	end
	task chk(input [31:0] s, input [31:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (s !== e) begin
				error_cnt = error_cnt + 1;
				$display("mismatch at %0t: seen %h expected %h", $time, s, e);
			end
		end
	endtask
	task bus(input w, input [3:0] a, input [31:0] d);
		begin
			@(posedge clk_i);
			wb_cyc_i <= 1'h1;
			wb_stb_i <= 1'h1;
			wb_we_i <= w;
			wb_sel_i <= 4'hf;
			wb_adr_i <= a;
			wb_dat_i <= d;
			@(posedge clk_i);
			while (wb_ack_o !== 1'h1) @(posedge clk_i);
			rd = wb_dat_o;
			wb_cyc_i <= 1'h0;
			wb_stb_i <= 1'h0;
		end
	endtask
	task op(input [2:0] o, input [1:0] blk, input wp);
		begin
			bus(1'h1, 4'h4, {10'h0, blk, 20'h0});
			bus(1'h1, 4'h0, {27'h0, wp, 1'h1, o});
			repeat (4) @(posedge clk_i);
			st = 32'h1;
			while (st[0] !== 1'h0) begin
				bus(1'h0, 4'h8, 32'h0);
				st = rd;
			end
		end
	endtask
	task lkchk(input [1:0] blk, input wp, input [1:0] e);
		begin
			op(3'h3, blk, wp);
			chk({30'h0, st[2:1]}, {30'h0, e});
			bus(1'h0, 4'hc, 32'h0);
			chk(rd, {30'h0, e});
		end
	endtask
	task do_reset;
		begin
			rst_i <= 1'h1;
			repeat (8) @(posedge clk_i);
			rst_i <= 1'h0;
		end
	endtask
	// ----------------
	// Tests
	// ----------------
	initial begin
		do_reset;
		for (b = 0; b < 4; b = b + 1) lkchk(b[1:0], 1'h0, 2'h1);
		bus(1'h0, 4'h2, 32'h0);
		chk(rd, 32'h0);
		op(3'h1, 2'h1, 1'h0);
		lkchk(2'h1, 1'h0, 2'h0);
		lkchk(2'h2, 1'h0, 2'h1);
		op(3'h0, 2'h1, 1'h0);
		lkchk(2'h1, 1'h0, 2'h1);
		op(3'h1, 2'h1, 1'h0);
		op(3'h2, 2'h2, 1'h0);
		lkchk(2'h2, 1'h0, 2'h3);
		op(3'h1, 2'h2, 1'h0);
		lkchk(2'h2, 1'h0, 2'h3);
		op(3'h1, 2'h2, 1'h1);
		lkchk(2'h2, 1'h1, 2'h2);
		lkchk(2'h2, 1'h0, 2'h3);
		op(3'h5, 2'h3, 1'h0);
		op(3'h2, 2'h3, 1'h0);
		lkchk(2'h3, 1'h0, 2'h3);
		op(3'h6, 2'h3, 1'h0);
		op(3'h4, 2'h3, 1'h0);
		chk({31'h0, st[4]}, 32'h0);
		inj <= 2'h1;
		op(3'h4, 2'h3, 1'h0);
		chk({31'h0, st[3]}, 32'h1);
		inj <= 2'h2;
		op(3'h5, 2'h3, 1'h0);
		op(3'h0, 2'h3, 1'h0);
		inj <= 2'h0;
		op(3'h6, 2'h3, 1'h0);
		op(3'h4, 2'h3, 1'h0);
		chk({31'h0, st[4]}, 32'h1);
		psusp <= 1'h1;
		op(3'h4, 2'h0, 1'h0);
		chk({31'h0, st[5]}, 32'h1);
		op(3'h0, 2'h1, 1'h0);
		chk({31'h0, st[6]}, 32'h1);
		lkchk(2'h1, 1'h0, 2'h0);
		psusp <= 1'h0;
		op(3'h4, 2'h0, 1'h0);
		op(3'h7, 2'h0, 1'h0);
		chk({30'h0, st[4:3]}, 32'h0);
		do_reset;
		lkchk(2'h1, 1'h0, 2'h1);
		lkchk(2'h2, 1'h0, 2'h1);
		stop_test;
	end
endmodule // flash_block_lock_control_bench
